// file: core/pss_sequencer.v
// Power sequencer and supervisor with an APB register slave.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "pss_consts.vh"

// Operation
// - Power-fail flag follows power-fail comparator.
// - Reset held low while monitor level low.
// - Reset released 200ms after level rises.
// - Watchdog runs only when its input driven.
// - Any watchdog input edge restarts watchdog.
// - Expiry after 1.6s without watchdog edge.
// - Expiry pulses reset 200ms, repeats each 1.6s.
// - Watchdog disabled when both diodes disabled.
// - On/off toggled by pushbutton or mode command.
// - Power-on releases enable, blanks kill 400ms.
// - Kill low at blanking end forces shutdown.
// - Power-off starts 400ms off-wait timer.
// - Watchdog edges restart the off-wait timer.
// - Kill low ends off-wait at once.
// - Off-wait end drives enable low.
// - 400ms lockout holds enable low.
// - Lockout end returns to reset state.
// - Kill low in normal operation drops enable.
module pss_sequencer #(
  parameter TICK_CYCLES = `PSS_TICK_NS / `PSS_CLK_NS
) (
  // Clock and control
  input wire clock,
  input wire rst_n,
  input wire clkEn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PSS_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Comparator and processor inputs
  input wire powerFailSenseIn,
  input wire voltageMonitorIn,
  input wire watchdogEdgeIn,
  input wire watchdogDrivenIn,
  input wire kill_n,
  input wire pushbuttonEvent,
  input wire modeSelectA,
  input wire modeSelectB,
  input wire diodesOffIn,
  // Open-drain outputs
  output reg powerFailFlag_nOut,
  output reg powerFailFlag_nOe,
  output reg supervisorReset_nOut,
  output reg supervisorReset_nOe,
  output reg converterEnableOut,
  output reg converterEnableOe,
  // Internal on/off state
  output reg onOff_q
);

  // ****************************************
  // Derived interval lengths in ticks
  // ****************************************
  localparam [`PSS_TMR_W-1:0] RST_TICKS = `PSS_T_RST_MS / `PSS_TICK_MS;
  localparam [`PSS_TMR_W-1:0] WDE_TICKS = `PSS_WATCHDOG_TIMEOUT_MS / `PSS_TICK_MS;
  localparam [`PSS_TMR_W-1:0] BLANK_TICKS = `PSS_T_BLANK_MS / `PSS_TICK_MS;
  localparam [`PSS_TMR_W-1:0] OFFWAIT_TICKS = `PSS_T_OFFWAIT_MS / `PSS_TICK_MS;
  localparam [`PSS_TMR_W-1:0] LOCKOUT_TICKS = `PSS_T_LOCKOUT_MS / `PSS_TICK_MS;
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  // ****************************************
  // Synchronisers
  // ****************************************
  // Only the second and third stages are looked at, so metastability cannot reach logic.
  reg [`PSS_SYN_W-1:0] syncA_q;
  reg [`PSS_SYN_W-1:0] syncB_q;
  reg [`PSS_SYN_W-1:0] syncC_q;
  wire [`PSS_SYN_W-1:0] rawIn;
  assign rawIn = {modeSelectB, modeSelectA, kill_n, watchdogDrivenIn,
                  watchdogEdgeIn, voltageMonitorIn, powerFailSenseIn};

  always @(posedge clock) begin
    if (!rst_n) begin
      syncA_q <= {`PSS_SYN_W{1'b0}};
      syncB_q <= {`PSS_SYN_W{1'b0}};
      syncC_q <= {`PSS_SYN_W{1'b0}};
    end else if (clkEn) begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
    end
  end

  wire vmHigh = syncB_q[`PSS_SYN_VM];
  wire killLow = !syncB_q[`PSS_SYN_KILL];
  wire wdeEdge = syncB_q[`PSS_SYN_WDE] ^ syncC_q[`PSS_SYN_WDE];
  wire maRise = syncB_q[`PSS_SYN_MA] & !syncC_q[`PSS_SYN_MA];
  wire mbRise = syncB_q[`PSS_SYN_MB] & !syncC_q[`PSS_SYN_MB];
  wire mbFall = !syncB_q[`PSS_SYN_MB] & syncC_q[`PSS_SYN_MB];

  // ****************************************
  // Common prescaler
  // ****************************************
  reg [31:0] prescale_q;
  reg tick_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      prescale_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (clkEn) begin
      tick_q <= (prescale_q == TICK_LAST);
      if (prescale_q == TICK_LAST) begin
        prescale_q <= 32'h00000000;
      end else begin
        prescale_q <= prescale_q + 32'h00000001;
      end
    end
  end

  // ****************************************
  // Control register
  // ****************************************
  reg [31:0] ctrl_q;
  wire wdAllow = ctrl_q[`PSS_CTRL_WDALLOW];
  wire wdActive = syncB_q[`PSS_SYN_WDDRV] & !diodesOffIn & wdAllow;

  // ****************************************
  // Supervisor
  // ****************************************
  reg [1:0] svState_q;
  reg [`PSS_TMR_W-1:0] svTmr_q;

  always @(posedge clock) begin
    if (!rst_n) begin
      svState_q <= `PSS_SV_HOLD;
      svTmr_q <= {`PSS_TMR_W{1'b0}};
    end else if (clkEn) begin
      if (!vmHigh) begin
        svState_q <= `PSS_SV_HOLD;
        svTmr_q <= {`PSS_TMR_W{1'b0}};
      end else begin
        case (svState_q)
          `PSS_SV_HOLD: begin
            svState_q <= `PSS_SV_DELAY;
            svTmr_q <= {`PSS_TMR_W{1'b0}};
          end
          `PSS_SV_DELAY: begin
            if (tick_q && svTmr_q == RST_TICKS - 1'b1) begin
              svState_q <= `PSS_SV_RUN;
              svTmr_q <= {`PSS_TMR_W{1'b0}};
            end else if (tick_q) begin
              svTmr_q <= svTmr_q + 1'b1;
            end
          end
          `PSS_SV_RUN: begin
            if (!wdActive || wdeEdge) begin
              svTmr_q <= {`PSS_TMR_W{1'b0}};
            end else if (tick_q && svTmr_q == WDE_TICKS - 1'b1) begin
              svState_q <= `PSS_SV_DELAY;
              svTmr_q <= {`PSS_TMR_W{1'b0}};
            end else if (tick_q) begin
              svTmr_q <= svTmr_q + 1'b1;
            end
          end
          default: begin
            svState_q <= `PSS_SV_HOLD;
            svTmr_q <= {`PSS_TMR_W{1'b0}};
          end
        endcase
      end
    end
  end

  // ****************************************
  // Power sequencer
  // ****************************************
  reg [2:0] seqState_q;
  reg [`PSS_TMR_W-1:0] seqTmr_q;
  wire onCmd = pushbuttonEvent | mbRise;
  wire offCmd = pushbuttonEvent | maRise | mbFall;

  always @(posedge clock) begin
    if (!rst_n) begin
      seqState_q <= `PSS_SEQ_IDLE;
      seqTmr_q <= {`PSS_TMR_W{1'b0}};
      onOff_q <= 1'b0;
    end else if (clkEn) begin
      case (seqState_q)
        `PSS_SEQ_IDLE: begin
          seqTmr_q <= {`PSS_TMR_W{1'b0}};
          if (onCmd) begin
            onOff_q <= 1'b1;
            seqState_q <= `PSS_SEQ_BLANK;
          end
        end
        `PSS_SEQ_BLANK: begin
          if (tick_q && seqTmr_q == BLANK_TICKS - 1'b1) begin
            seqTmr_q <= {`PSS_TMR_W{1'b0}};
            if (killLow) begin
              onOff_q <= 1'b0;
              seqState_q <= `PSS_SEQ_LOCKOUT;
            end else begin
              seqState_q <= `PSS_SEQ_ON;
            end
          end else if (tick_q) begin
            seqTmr_q <= seqTmr_q + 1'b1;
          end
        end
        `PSS_SEQ_ON: begin
          seqTmr_q <= {`PSS_TMR_W{1'b0}};
          if (killLow) begin
            onOff_q <= 1'b0;
            seqState_q <= `PSS_SEQ_LOCKOUT;
          end else if (offCmd) begin
            onOff_q <= 1'b0;
            seqState_q <= `PSS_SEQ_OFFWAIT;
          end
        end
        `PSS_SEQ_OFFWAIT: begin
          if (killLow || (tick_q && seqTmr_q == OFFWAIT_TICKS - 1'b1)) begin
            seqTmr_q <= {`PSS_TMR_W{1'b0}};
            seqState_q <= `PSS_SEQ_LOCKOUT;
          end else if (wdeEdge) begin
            seqTmr_q <= {`PSS_TMR_W{1'b0}};
          end else if (tick_q) begin
            seqTmr_q <= seqTmr_q + 1'b1;
          end
        end
        `PSS_SEQ_LOCKOUT: begin
          if (tick_q && seqTmr_q == LOCKOUT_TICKS - 1'b1) begin
            seqTmr_q <= {`PSS_TMR_W{1'b0}};
            seqState_q <= `PSS_SEQ_IDLE;
          end else if (tick_q) begin
            seqTmr_q <= seqTmr_q + 1'b1;
          end
        end
        default: begin
          seqState_q <= `PSS_SEQ_IDLE;
          seqTmr_q <= {`PSS_TMR_W{1'b0}};
          onOff_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Open-drain outputs
  // ****************************************
  // Enable is released only in blanking, normal operation and off-wait.
  wire enRelease = (seqState_q == `PSS_SEQ_BLANK) || (seqState_q == `PSS_SEQ_ON) ||
                   (seqState_q == `PSS_SEQ_OFFWAIT);

  always @(posedge clock) begin
    if (!rst_n) begin
      powerFailFlag_nOut <= 1'b0;
      powerFailFlag_nOe <= 1'b1;
      supervisorReset_nOut <= 1'b0;
      supervisorReset_nOe <= 1'b1;
      converterEnableOut <= 1'b0;
      converterEnableOe <= 1'b1;
    end else if (clkEn) begin
      powerFailFlag_nOe <= !syncB_q[`PSS_SYN_PFS];
      supervisorReset_nOe <= (svState_q != `PSS_SV_RUN);
      converterEnableOe <= !enRelease;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state: data is latched first, the write lands on the final edge.
  wire access = psel & penable;
  wire hitStatus = (paddr == `PSS_OFF_STATUS);
  wire hitCtrl = (paddr == `PSS_OFF_CTRL);
  wire [31:0] statusWord = {23'h000000, onOff_q, !converterEnableOe,
                            !supervisorReset_nOe, !powerFailFlag_nOe,
                            seqState_q, svState_q};

  always @(posedge clock) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_q <= `PSS_CTRL_RESET;
    end else if (clkEn) begin
      if (access && !pready) begin
        pready <= 1'b1;
        pslverr <= !(hitStatus || hitCtrl);
        if (pwrite) begin
          prdata <= 32'h00000000;
        end else if (hitStatus) begin
          prdata <= statusWord;
        end else if (hitCtrl) begin
          prdata <= ctrl_q;
        end else begin
          prdata <= 32'h00000000;
        end
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        if (access && pwrite && hitCtrl) begin
          ctrl_q <= {31'h00000000, pwdata[`PSS_CTRL_WDALLOW]};
        end
      end
    end
  end

endmodule // pss_sequencer

// file: pkg/pss_consts.vh
// Constants for the power sequencer and supervisor block.
`ifndef PSS_CONSTS_VH
`define PSS_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define PSS_CLK_NS 50
`define PSS_TICK_NS 1000000
`define PSS_T_RST_MS 200
`define PSS_WATCHDOG_TIMEOUT_MS 1600
`define PSS_T_BLANK_MS 400
`define PSS_T_OFFWAIT_MS 400
`define PSS_T_LOCKOUT_MS 400
`define PSS_TICK_MS 1
`define PSS_TMR_W 11

// ****************************************
// Register map
// ****************************************
`define PSS_ADDR_W 12
`define PSS_OFF_STATUS 12'h000
`define PSS_OFF_CTRL 12'h004
`define PSS_CTRL_WDALLOW 0
`define PSS_CTRL_RESET 32'h00000001

// ****************************************
// Sequencer states
// ****************************************
`define PSS_SEQ_IDLE 3'h0
`define PSS_SEQ_BLANK 3'h1
`define PSS_SEQ_ON 3'h2
`define PSS_SEQ_OFFWAIT 3'h3
`define PSS_SEQ_LOCKOUT 3'h4

// ****************************************
// Supervisor states
// ****************************************
`define PSS_SV_HOLD 2'h0
`define PSS_SV_DELAY 2'h1
`define PSS_SV_RUN 2'h2

// ****************************************
// Synchroniser bit positions
// ****************************************
`define PSS_SYN_W 7
`define PSS_SYN_PFS 0
`define PSS_SYN_VM 1
`define PSS_SYN_WDE 2
`define PSS_SYN_WDDRV 3
`define PSS_SYN_KILL 4
`define PSS_SYN_MA 5
`define PSS_SYN_MB 6

`endif

// file: testbench/pss_assertions.sv
// Concurrent checks on the comparator, reset and enable pins.
`timescale 1ns/100ps
module pss_assertions #(
  parameter TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Inputs
  input wire logic powerFailSenseIn,
  input wire logic voltageMonitorIn,
  input wire logic watchdogEdgeIn,
  input wire logic kill_n,
  // Outputs
  input wire logic powerFailFlag_nOe,
  input wire logic supervisorReset_nOe,
  input wire logic converterEnableOe
);
  localparam int T = TICK_CYCLES;
  logic [15:0] vmCnt_q, wdCnt_q, hiCnt_q, relCnt_q;
  logic wdPrev_q;
  function automatic logic [15:0] inc(input logic [15:0] c);
    return c + {15'h0, ~&c};
  endfunction
  // ****************************************
  // Interval counters
  // ****************************************
  // Counters saturate so that a long run never wraps into a false window.
  always @(posedge clock) begin
    wdPrev_q <= watchdogEdgeIn;
    vmCnt_q <= (!rst_n || !voltageMonitorIn) ? 16'h0 : inc(vmCnt_q);
    wdCnt_q <= (!rst_n || supervisorReset_nOe || watchdogEdgeIn != wdPrev_q) ? 16'h0
      : inc(wdCnt_q);
    hiCnt_q <= (!rst_n || !supervisorReset_nOe) ? 16'h0 : inc(hiCnt_q);
    relCnt_q <= (!rst_n || converterEnableOe) ? 16'h0 : inc(relCnt_q);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_PF_HIGH: assert property (powerFailSenseIn [*6] |-> !powerFailFlag_nOe)
    else $error("power-fail flag pulled while input high");
  AST_PF_LOW: assert property (!powerFailSenseIn [*6] |-> powerFailFlag_nOe)
    else $error("power-fail flag released while input low");
  AST_RST_HOLD: assert property (!voltageMonitorIn [*6] |-> supervisorReset_nOe)
    else $error("reset released while monitor low");
  AST_RST_MIN: assert property ($fell(supervisorReset_nOe) |-> vmCnt_q >= 198*T)
    else $error("reset released too early");
  AST_RST_MAX: assert property (vmCnt_q == 203*T |-> !supervisorReset_nOe)
    else $error("reset release late");
  AST_WD_MIN: assert property ($rose(supervisorReset_nOe) && voltageMonitorIn
    |-> wdCnt_q >= 1598*T) else $error("watchdog expired early");
  AST_WD_PULSE: assert property ($fell(supervisorReset_nOe) && vmCnt_q > 1000*T
    |-> hiCnt_q >= 198*T && hiCnt_q <= 202*T) else $error("watchdog pulse width wrong");
  AST_EN_BLANK: assert property ($rose(converterEnableOe) |-> relCnt_q >= 397*T)
    else $error("enable dropped inside blanking");
  AST_KILL_DROP: assert property (relCnt_q > 403*T && $fell(kill_n)
    |-> ##[1:6] converterEnableOe) else $error("kill did not drop enable");
endmodule // pss_assertions

// file: testbench/pss_cpu_model.sv
// Behavioural processor driving the kill and watchdog pins.
`timescale 1ns/100ps
module pss_cpu_model (
  // Clock
  input wire logic clock,
  // Bench requests
  input wire logic drive,
  input wire logic kick,
  input wire logic killLow,
  // Pins
  output logic watchdogEdgeIn,
  output logic watchdogDrivenIn,
  output logic kill_n
);
  initial begin
    watchdogEdgeIn = 1'b0;
    watchdogDrivenIn = 1'b1;
    kill_n = 1'b0;
  end
  // A floating pin wanders, so it toggles every cycle rather than holding.
  always @(posedge clock) begin
    watchdogDrivenIn <= drive;
    kill_n <= !killLow;
    if (kick || !drive) begin
      watchdogEdgeIn <= !watchdogEdgeIn;
    end
  end
endmodule // pss_cpu_model

// file: testbench/tb_top.sv
// Self-checking bench for the power sequencer and supervisor.
`timescale 1ns/100ps
`include "pss_consts.vh"
module tb_top;
  localparam int TK = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pfs = 1'b0;
  logic vm = 1'b0;
  logic pb = 1'b0;
  logic ma = 1'b0;
  logic mb = 1'b0;
  logic dOff = 1'b0;
  logic drive = 1'b1;
  logic kick = 1'b0;
  logic killLow = 1'b1;
  wire [31:0] prdata;
  wire pready, pslverr, pfOe, rstOe, enOe, onOff, watchdog_edge_in, wdd, kill_n;
  int errors = 0;
  int tests_run = 0;
  logic [31:0] r;
  logic e;
  int n;
  always #25 clock = ~clock;
  pss_sequencer #(.TICK_CYCLES(TK)) uut (.clock(clock), .rst_n(rst_n), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .powerFailSenseIn(pfs),
    .voltageMonitorIn(vm), .watchdogEdgeIn(watchdog_edge_in), .watchdogDrivenIn(wdd), .kill_n(kill_n),
    .pushbuttonEvent(pb), .modeSelectA(ma), .modeSelectB(mb), .diodesOffIn(dOff),
    .powerFailFlag_nOut(), .powerFailFlag_nOe(pfOe), .supervisorReset_nOut(),
    .supervisorReset_nOe(rstOe), .converterEnableOut(), .converterEnableOe(enOe),
    .onOff_q(onOff));
  pss_cpu_model cpu (.clock(clock), .drive(drive), .kick(kick), .killLow(killLow),
    .watchdogEdgeIn(watchdog_edge_in), .watchdogDrivenIn(wdd), .kill_n(kill_n));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pulses the watchdog through the processor model, or the pushbutton.
  task pulse(input logic s);
    @(posedge clock);
    if (s) kick <= 1'b1;
    else pb <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    pb <= 1'b0;
  endtask
  task waitOn(input logic s, input logic v);
    n = 0;
    while (((s ? rstOe : enOe) !== v) && n < 20000) begin
      @(posedge clock);
      n++;
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(89));
    cyc(4);
    rst_n <= 1'b1;
    cyc(8);
    apb(0, `PSS_OFF_STATUS, 0);
    chk("status", r, 32'h000);
    apb(0, `PSS_OFF_CTRL, 0);
    chk("ctrl", r, `PSS_CTRL_RESET);
    chk("ctrl err", e, 0);
    n = $urandom;
    apb(1, `PSS_OFF_CTRL, n);
    apb(0, `PSS_OFF_CTRL, 0);
    chk("ctrl rw", r, n & 1);
    apb(0, 12'($urandom_range(1023, 2) * 4), 0);
    chk("bad addr err", e, 1);
    chk("bad addr data", r, 0);
    apb(1, `PSS_OFF_CTRL, 1);
    $display("test apb done");
    repeat (8) begin
      pfs <= 1'($urandom);
      cyc(6);
      chk("pf", pfOe, !pfs);
    end
    vm <= 1'b1;
    waitOn(1, 0);
    chk("rst delay", n >= 198*TK && n <= 203*TK, 1);
    repeat (3) begin
      cyc($urandom_range(1400, 1000) * TK);
      pulse(1);
      chk("rst kept", rstOe, 0);
    end
    waitOn(1, 1);
    chk("wd expiry", n >= 1598*TK && n <= 1603*TK, 1);
    waitOn(1, 0);
    chk("wd pulse", n >= 198*TK && n <= 202*TK, 1);
    dOff <= 1'b1;
    cyc(1700*TK);
    chk("wd diodes off", rstOe, 0);
    dOff <= 1'b0;
    drive <= 1'b0;
    cyc(1700*TK);
    chk("wd floating", rstOe, 0);
    vm <= 1'b0;
    cyc(6);
    chk("rst low", rstOe, 1);
    drive <= 1'b1;
    $display("test supervisor done");
    pulse(0);
    cyc(6);
    chk("on", onOff, 1);
    chk("en released", enOe, 0);
    waitOn(0, 1);
    chk("blank end", n >= 397*TK && n <= 402*TK, 1);
    cyc(2);
    chk("abort clears", onOff, 0);
    cyc(200*TK);
    apb(0, `PSS_OFF_STATUS, 0);
    chk("lockout", {r[7], r[4:2]}, 4'h4);
    cyc(210*TK);
    apb(0, `PSS_OFF_STATUS, 0);
    chk("idle", {r[7], r[4:2]}, 4'h0);
    mb <= 1'b1;
    cyc(6);
    chk("on cmd", onOff, 1);
    cyc(100*TK);
    killLow <= 1'b0;
    cyc(310*TK);
    chk("normal on", enOe, 0);
    pulse(0);
    repeat (2) begin
      cyc(300*TK);
      pulse(1);
    end
    chk("off extended", enOe, 0);
    waitOn(0, 1);
    chk("off wait", n >= 397*TK && n <= 402*TK, 1);
    cyc(410*TK);
    pulse(0);
    cyc(410*TK);
    ma <= 1'b1;
    cyc(100*TK);
    chk("wait running", enOe, 0);
    killLow <= 1'b1;
    waitOn(0, 1);
    chk("kill ends wait", n <= 8, 1);
    cyc(410*TK);
    killLow <= 1'b0;
    pulse(0);
    cyc(410*TK);
    chk("on again", enOe, 0);
    killLow <= 1'b1;
    waitOn(0, 1);
    chk("kill drop", n <= 8, 1);
    cyc(410*TK);
    killLow <= 1'b0;
    mb <= 1'b0;
    cyc(6);
    mb <= 1'b1;
    cyc(410*TK);
    chk("mode on", onOff, 1);
    mb <= 1'b0;
    cyc(6);
    chk("mode off", onOff, 0);
    $display("test sequencer done");
    final_report;
  end
  initial begin
    #4000000;
    errors++;
    final_report;
  end
endmodule // tb_top
bind pss_sequencer pss_assertions #(.TICK_CYCLES(TICK_CYCLES)) asrt (.clock(clock),
  .rst_n(rst_n), .powerFailSenseIn(powerFailSenseIn), .voltageMonitorIn(voltageMonitorIn),
  .watchdogEdgeIn(watchdogEdgeIn), .kill_n(kill_n), .powerFailFlag_nOe(powerFailFlag_nOe),
  .supervisorReset_nOe(supervisorReset_nOe), .converterEnableOe(converterEnableOe));
